/* design/sdhm_defines.svh */
// Register indices, reset values and field positions of the overhead error monitor.
`ifndef SDHM_DEFINES_SVH
`define SDHM_DEFINES_SVH
// What this block does
// - Count B1 bit errors, 16 bits, overflow interrupts.
// - Count B1 block errors, 16 bits, overflow interrupts.
// - Count B2 bit errors, 16 bits, overflow interrupts.
// - Count B2 block errors, 16 bits, overflow interrupts.
// - Count B3 bit errors, 16 bits, overflow interrupts.
// - Count B3 block errors, 16 bits, overflow interrupts.
// - Count section remote errors, overflow interrupts.
// - Count path remote errors, overflow interrupts.
// - Three 8-bit pointer event counters with overflow.
// - B2 counters have degrade and fail thresholds.
// - Count above threshold raises an interrupt request.
// - Threshold split: high byte, then low byte.
// - Read N keeps count; N-1 clears after.
// - Enable bit 1 runs counter, 0 stops.
// - Reset/halt register preset by chiplet reset.
// - Mode events latch and stay set.
// - Counter pending bit shows active request.
// - Unmasked counter pending sets summary pointer.
// - Unmasked user pending sets summary pointer.
// - Unmasked summary bits drive interrupt line.
// - Summary holds fatal flags and pointer bits.

// Word indices; the byte address is four times the index.
// Counter k sits at index 2k+1, its clearing alias at 2k.
`define SDHM_IDX_CNT_LAST 7'h15
`define SDHM_IDX_SNAP 7'h16
// Threshold t: high byte at 24+2t, low byte at 25+2t.
`define SDHM_IDX_THR_BASE 7'h18
`define SDHM_IDX_THR_LAST 7'h2B
`define SDHM_IDX_CNTEN_A 7'h2C
`define SDHM_IDX_CNTEN_B 7'h2D
`define SDHM_IDX_RESET_HALT 7'h2E
`define SDHM_IDX_MODE_LATCH 7'h2F
`define SDHM_IDX_TOP_SUMMARY 7'h30
`define SDHM_IDX_TOP_MASK 7'h31
`define SDHM_IDX_CPEND0 7'h32
`define SDHM_IDX_CPEND2 7'h34
`define SDHM_IDX_CMASK0 7'h35
`define SDHM_IDX_CMASK2 7'h37
`define SDHM_IDX_USER_PEND 7'h38
`define SDHM_IDX_USER_MASK 7'h39

// Reset values.
`define SDHM_RESET_HALT_DEFAULT 8'h00
`define SDHM_THR_DEFAULT 16'hFFFF
`define SDHM_MASK_DEFAULT 8'h00
`define SDHM_CNTEN_DEFAULT 8'h00

// Reset/halt register fields.
`define SDHM_RH_CLEAR 0
`define SDHM_RH_HALT 1

// Summary register fields.
`define SDHM_SUM_CNT_PTR 0
`define SDHM_SUM_USER_PTR 1
`define SDHM_SUM_FATAL_LSB 2

// Counter and threshold counts.
`define SDHM_NUM_CNT 11
`define SDHM_NUM_WIDE 8
`define SDHM_NUM_THR 10
`endif

/* design/sdhm_pkg.sv */
// Types shared by the overhead error monitor modules.
package sdhm_pkg;
  // Bus answer state, one-hot.
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_done = 2'b10
  } sdhm_apb_e;
  // One register byte.
  typedef logic [7:0] sdhm_byte_t;
  // A count as carried between modules, 8-bit counts zero-extended.
  typedef logic [15:0] sdhm_count_t;
endpackage

/* design/sdhm_cnt_if.sv */
// Interface between the register logic and the counter bank.
`timescale 1ns/1ns
`default_nettype none
interface sdhm_cnt_if #(
  parameter int NC = 11
);
  logic [NC-1:0] inc; // Count event for each counter.
  logic [NC-1:0] run; // Counter may advance.
  logic [NC-1:0] clr; // Zero the counter this cycle.
  logic [NC-1:0] ovf; // One-cycle pulse after a wrap.
  sdhm_pkg::sdhm_count_t count [NC]; // Current counts.
  modport ctl (output inc, output run, output clr, input ovf, input count);
  modport bank (input inc, input run, input clr, output ovf, output count);
endinterface
`default_nettype wire

/* design/sdhm_counter_bank.sv */
// Bank of event counters, the first NW of them 16 bits wide, the rest 8 bits.
`timescale 1ns/1ns
`default_nettype none
module sdhm_counter_bank #(
  parameter int NC = 11,
  parameter int NW = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  sdhm_cnt_if.bank cif
);
  genvar i;
  generate
    for (i = 0; i < NC; i++) begin : g_cnt
      localparam int W = (i < NW) ? 16 : 8;
      logic [W-1:0] value; // Running count.
      logic ovf_q; // Wrap pulse.
      logic step; // This counter advances now.
      assign step = cif.inc[i] & cif.run[i];
      // Clearing wins over holding, but an event in the clearing cycle is kept as one.
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          value <= '0;
        end else if (cif.clr[i]) begin
          value <= step ? W'(1) : '0;
        end else if (step) begin
          value <= value + W'(1);
        end
      end
      // The wrap from all ones to zero is reported as a one-cycle pulse in the cycle the count reads zero.
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          ovf_q <= 1'b0;
        end else begin
          ovf_q <= step & ~cif.clr[i] & (&value);
        end
      end
      assign cif.count[i] = 16'(value);
      assign cif.ovf[i] = ovf_q;
    end
  endgenerate
endmodule // sdhm_counter_bank
`default_nettype wire

/* design/sdhm_event_latch.sv */
// Sticky event register: hardware sets bits, software clears them by writing ones.
`timescale 1ns/1ns
`default_nettype none
module sdhm_event_latch #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);
  // A set in the clearing cycle wins, so no event is lost.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= (q & ~clr) | set;
    end
  end
endmodule // sdhm_event_latch
`default_nettype wire

/* design/sdhm_monitor.sv */
// Top of the overhead error monitor: APB registers, thresholds and interrupt tree.
`timescale 1ns/1ns
`default_nettype none
`include "sdhm_defines.svh"
module sdhm_monitor #(
  parameter int NC = `SDHM_NUM_CNT,
  parameter int NW = `SDHM_NUM_WIDE,
  parameter int NT = `SDHM_NUM_THR
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [10:0] count_event,
  input wire logic [7:0] mode_event,
  input wire logic [7:0] user_event,
  input wire logic [5:0] fatal_event,
  input wire logic chiplet_reset_in,
  output logic [7:0] reset_halt,
  output logic chiplet_irq_out
);

  // ********************************************************
  // Declarations
  // ********************************************************

  // Counter feeding each threshold; the B2 pair each feed two.
  localparam int THR_SRC [10] = '{0, 1, 2, 2, 3, 3, 4, 5, 6, 7};

  sdhm_pkg::sdhm_apb_e state; // Bus answer state.
  logic [6:0] idx; // Word index of the access.
  logic in_range; // Address is aligned and within the block.
  logic done; // Access phase completes at this edge.
  logic wr_done; // A write takes effect at this edge.
  logic rd_done; // A read completes at this edge.
  sdhm_pkg::sdhm_byte_t rd_byte; // Read data for the current address.
  logic map_ok; // Current address is mapped.
  logic [3:0] cnt_sel; // Counter selected by a counter address.
  logic cnt_rd; // Completed read of a counter low byte.
  logic [6:0] thr_off; // Offset into the threshold range.
  logic [3:0] thr_sel; // Threshold selected.
  logic [1:0] cp_sel; // Byte of a 24-bit pending or mask register.
  logic [10:0] rd_clr; // Clearing requests from alias reads.
  sdhm_pkg::sdhm_byte_t snapshot_middle_byte; // High byte caught at a low byte read.
  logic [15:0] thr [10]; // Thresholds, as programmed.
  logic [9:0] exceed; // Count is above its threshold.
  logic [7:0] counter_enable_a; // Run bits of the 16-bit counters.
  logic [2:0] counter_enable_b; // Run bits of the 8-bit counters.
  logic [7:0] top_interrupt_mask; // Summary mask.
  logic [23:0] counter_irq_mask; // Counter pending mask.
  logic [7:0] user_irq_mask; // User pending mask.
  logic [23:0] counter_irq_pending; // Sticky counter requests.
  logic [7:0] user_irq_pending; // Sticky user requests.
  logic [7:0] mode_event_latch; // Sticky mode events.
  logic [5:0] fatal_flags; // Sticky fatal events.
  logic [7:0] top_interrupt_summary; // Fatal flags and pointers.
  logic [23:0] cp_clr; // Clearing bits for counter pending.
  logic [23:0] cp_shift; // Pending shifted to the read byte.
  logic [23:0] cm_shift; // Mask shifted to the read byte.
  logic [23:0] cm_wr; // Write data moved to its byte.

  sdhm_cnt_if #(.NC(NC)) cif ();

  // ********************************************************
  // Address decode
  // ********************************************************

  assign idx = paddr[8:2];
  assign in_range = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0);
  assign done = (state == sdhm_pkg::st_done) && psel && penable;
  assign wr_done = done && pwrite && map_ok;
  assign rd_done = done && !pwrite && map_ok;
  assign cnt_sel = idx[4:1];
  assign cnt_rd = rd_done && (idx <= `SDHM_IDX_CNT_LAST);
  assign thr_off = idx - `SDHM_IDX_THR_BASE;
  assign thr_sel = thr_off[4:1];
  assign cp_sel = (idx >= `SDHM_IDX_CMASK0) ? 2'(idx - `SDHM_IDX_CMASK0) :
                  2'(idx - `SDHM_IDX_CPEND0);
  assign cp_shift = counter_irq_pending >> {cp_sel, 3'h0};
  assign cm_shift = counter_irq_mask >> {cp_sel, 3'h0};
  assign cm_wr = 24'(pwdata[7:0]) << {cp_sel, 3'h0};

  // Read data and mapping of the address under access; unmapped reads answer zero.
  always_comb begin
    rd_byte = 8'h00;
    map_ok = 1'b1;
    if (!in_range) begin
      map_ok = 1'b0;
    end else if (idx <= `SDHM_IDX_CNT_LAST) begin
      // Both the plain address and its alias give the low byte.
      rd_byte = cif.count[cnt_sel][7:0];
    end else if (idx >= `SDHM_IDX_THR_BASE && idx <= `SDHM_IDX_THR_LAST) begin
      // High byte first, low byte second.
      rd_byte = thr_off[0] ? thr[thr_sel][7:0] : thr[thr_sel][15:8];
    end else if (idx >= `SDHM_IDX_CPEND0 && idx <= `SDHM_IDX_CPEND2) begin
      rd_byte = cp_shift[7:0];
    end else if (idx >= `SDHM_IDX_CMASK0 && idx <= `SDHM_IDX_CMASK2) begin
      rd_byte = cm_shift[7:0];
    end else begin
      case (idx)
        `SDHM_IDX_SNAP: begin
          rd_byte = snapshot_middle_byte;
        end
        `SDHM_IDX_CNTEN_A: begin
          rd_byte = counter_enable_a;
        end
        `SDHM_IDX_CNTEN_B: begin
          rd_byte = {5'h00, counter_enable_b};
        end
        `SDHM_IDX_RESET_HALT: begin
          rd_byte = reset_halt;
        end
        `SDHM_IDX_MODE_LATCH: begin
          rd_byte = mode_event_latch;
        end
        `SDHM_IDX_TOP_SUMMARY: begin
          rd_byte = top_interrupt_summary;
        end
        `SDHM_IDX_TOP_MASK: begin
          rd_byte = top_interrupt_mask;
        end
        `SDHM_IDX_USER_PEND: begin
          rd_byte = user_irq_pending;
        end
        `SDHM_IDX_USER_MASK: begin
          rd_byte = user_irq_mask;
        end
        default: begin
          map_ok = 1'b0;
        end
      endcase
    end
  end

  // ********************************************************
  // APB answer
  // ********************************************************

  // Read data is caught at the setup edge and the answer comes in the first
  // access cycle, so every transfer takes exactly two cycles.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= sdhm_pkg::st_idle;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      case (state)
        sdhm_pkg::st_idle: begin
          if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr <= !map_ok;
            pready <= 1'b1;
            state <= sdhm_pkg::st_done;
          end
        end
        sdhm_pkg::st_done: begin
          if (psel && penable) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            state <= sdhm_pkg::st_idle;
          end
        end
        default: begin
          state <= sdhm_pkg::st_idle;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

  // ********************************************************
  // Counters
  // ********************************************************

  // A completed read of the alias clears the counter after the data left.
  assign rd_clr = (cnt_rd && !idx[0]) ? (11'(1) << cnt_sel) : 11'h000;
  assign cif.inc = count_event;
  assign cif.clr = rd_clr | {11{reset_halt[`SDHM_RH_CLEAR]}};
  assign cif.run = {counter_enable_b, counter_enable_a} &
                   ~{11{reset_halt[`SDHM_RH_HALT]}};

  sdhm_counter_bank #(
    .NC(NC),
    .NW(NW)
  ) u_bank (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .cif(cif.bank)
  );

  // A low byte read catches the high byte at its completing edge, one cycle after the low byte was taken, so a carry in between splits the pair.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      snapshot_middle_byte <= 8'h00;
    end else if (cnt_rd) begin
      snapshot_middle_byte <= cif.count[cnt_sel][15:8];
    end
  end

  // ********************************************************
  // Thresholds
  // ********************************************************

  // Thresholds reset to all ones, so none trips before software programs it.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int t = 0; t < 10; t++) begin
        thr[t] <= `SDHM_THR_DEFAULT;
      end
    end else if (wr_done && idx >= `SDHM_IDX_THR_BASE && idx <= `SDHM_IDX_THR_LAST) begin
      if (thr_off[0]) begin
        thr[thr_sel][7:0] <= pwdata[7:0];
      end else begin
        thr[thr_sel][15:8] <= pwdata[7:0];
      end
    end
  end

  // Each B2 counter feeds both its degrade and its fail threshold.
  genvar g;
  generate
    for (g = 0; g < NT; g++) begin : g_thr
      assign exceed[g] = cif.count[THR_SRC[g]] > thr[g];
    end
  endgenerate

  // ********************************************************
  // Control registers
  // ********************************************************

  // Counter enables; all counters stand still after reset.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      counter_enable_a <= `SDHM_CNTEN_DEFAULT;
      counter_enable_b <= 3'h0;
    end else if (wr_done && idx == `SDHM_IDX_CNTEN_A) begin
      counter_enable_a <= pwdata[7:0];
    end else if (wr_done && idx == `SDHM_IDX_CNTEN_B) begin
      counter_enable_b <= pwdata[2:0];
    end
  end

  // The chiplet reset presets this register, taking priority over a write.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reset_halt <= `SDHM_RESET_HALT_DEFAULT;
    end else if (chiplet_reset_in) begin
      reset_halt <= `SDHM_RESET_HALT_DEFAULT;
    end else if (wr_done && idx == `SDHM_IDX_RESET_HALT) begin
      reset_halt <= pwdata[7:0];
    end
  end

  // Masks all reset to zero, blocking every request.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      top_interrupt_mask <= `SDHM_MASK_DEFAULT;
      user_irq_mask <= `SDHM_MASK_DEFAULT;
      counter_irq_mask <= 24'h00_0000;
    end else if (wr_done) begin
      if (idx == `SDHM_IDX_TOP_MASK) begin
        top_interrupt_mask <= pwdata[7:0];
      end
      if (idx == `SDHM_IDX_USER_MASK) begin
        user_irq_mask <= pwdata[7:0];
      end
      if (idx >= `SDHM_IDX_CMASK0 && idx <= `SDHM_IDX_CMASK2) begin
        counter_irq_mask <= (counter_irq_mask & ~(24'h00_00FF << {cp_sel, 3'h0})) | cm_wr;
      end
    end
  end

  // ********************************************************
  // Event latches and interrupt tree
  // ********************************************************

  assign cp_clr = (wr_done && idx >= `SDHM_IDX_CPEND0 && idx <= `SDHM_IDX_CPEND2) ?
                  (24'(pwdata[7:0]) << {cp_sel, 3'h0}) : 24'h00_0000;

  // Overflows in bits 10:0, threshold oversteps in bits 20:11.
  sdhm_event_latch #(.W(24)) u_cnt_pend (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set({3'h0, exceed, cif.ovf}),
    .clr(cp_clr),
    .q(counter_irq_pending)
  );

  sdhm_event_latch #(.W(8)) u_user_pend (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set(user_event),
    .clr((wr_done && idx == `SDHM_IDX_USER_PEND) ? pwdata[7:0] : 8'h00),
    .q(user_irq_pending)
  );

  // Mode events stay latched after the condition ends.
  sdhm_event_latch #(.W(8)) u_mode (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set(mode_event),
    .clr((wr_done && idx == `SDHM_IDX_MODE_LATCH) ? pwdata[7:0] : 8'h00),
    .q(mode_event_latch)
  );

  sdhm_event_latch #(.W(6)) u_fatal (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set(fatal_event),
    .clr((wr_done && idx == `SDHM_IDX_TOP_SUMMARY) ? pwdata[7:2] : 6'h00),
    .q(fatal_flags)
  );

  // Pointer bits follow the unmasked pending bits and are not stored.
  assign top_interrupt_summary = {fatal_flags,
                                  |(user_irq_pending & user_irq_mask),
                                  |(counter_irq_pending & counter_irq_mask)};

  // The outgoing line is registered so it never glitches.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      chiplet_irq_out <= 1'b0;
    end else begin
      chiplet_irq_out <= |(top_interrupt_summary & top_interrupt_mask);
    end
  end

endmodule // sdhm_monitor
`default_nettype wire

/* sim/sdhm_irq_block.sv */
// Model of the interrupt block that faces the monitor's reset and interrupt pins.
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Interrupt block model
// ****************************************
module sdhm_irq_block (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic chiplet_irq_out,
  input wire logic reset_req,
  output logic chiplet_reset_in,
  output logic [7:0] irq_edges
);
  logic irq_q; // Last sampled interrupt level.
  // The chiplet reset is issued from a register, one cycle after a request.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      chiplet_reset_in <= 1'b0;
    end else begin
      chiplet_reset_in <= reset_req;
    end
  end
  // Rising edges of the interrupt line are counted, as a real handler would service them.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
      irq_edges <= 8'h00;
    end else begin
      irq_q <= chiplet_irq_out;
      if (chiplet_irq_out && !irq_q) begin
        irq_edges <= irq_edges + 8'h01;
      end
    end
  end
endmodule // sdhm_irq_block
`default_nettype wire

/* sim/sdhm_assertions.sv */
// Concurrent checks on the ports of the overhead error monitor.
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module sdhm_assertions (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chiplet_reset_in,
  input wire logic [7:0] reset_halt,
  input wire logic chiplet_irq_out
);
  logic wr_done; // A write completes at this edge.
  assign wr_done = psel && penable && pready && pwrite;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer in the cycle after setup");
  ready_cause_a: assert property ($rose(pready) |-> $past(psel && !penable))
    else $error("pready rose without a setup cycle");
  err_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr outside an answer or with data");
  data_upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chip_reset_a: assert property (chiplet_reset_in |=> reset_halt == 8'h00)
    else $error("chiplet reset did not preset reset_halt");
  halt_write_a: assert property (wr_done && paddr == 12'h0B8 && !chiplet_reset_in
    |=> reset_halt[1] == $past(pwdata[1]))
    else $error("halt bit did not follow its write");
  mask_off_irq_a: assert property (wr_done && paddr == 12'h0C4 && pwdata[7:0] == 8'h00
    |-> ##2 !chiplet_irq_out)
    else $error("interrupt line high with all top masks off");
  cover property (pslverr);
  cover property ($rose(chiplet_irq_out));
  cover property (chiplet_reset_in);
endmodule // sdhm_assertions
bind sdhm_monitor sdhm_assertions chk (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .chiplet_reset_in(chiplet_reset_in),
  .reset_halt(reset_halt), .chiplet_irq_out(chiplet_irq_out));
`default_nettype wire

/* sim/sdh_overhead_error_monitor_test.sv */
// Self-checking bench for the overhead error monitor.
`timescale 1ns/1ns
`default_nettype none
module sdh_overhead_error_monitor_test;
  // Four-state compare, so an unknown never passes for a match.
  `define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
  logic ref_clk, rstn, psel, penable, pwrite, reset_req, chiplet_reset_in;
  logic pready, pslverr, chiplet_irq_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [10:0] count_event;
  logic [7:0] mode_event, user_event, reset_halt, irq_edges, r;
  logic [5:0] fatal_event;
  logic e;
  int errors, checked, cycles;
  sdhm_monitor uut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_event(count_event), .mode_event(mode_event),
    .user_event(user_event), .fatal_event(fatal_event), .chiplet_reset_in(chiplet_reset_in),
    .reset_halt(reset_halt), .chiplet_irq_out(chiplet_irq_out));
  sdhm_irq_block irqb (.ref_clk(ref_clk), .rstn(rstn), .chiplet_irq_out(chiplet_irq_out),
    .reset_req(reset_req), .chiplet_reset_in(chiplet_reset_in), .irq_edges(irq_edges));
  // ****************************************
  // Clock, timeout and verdict
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // The overflow pass alone takes 65536 cycles, so the ceiling sits well above it.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      complete_run();
    end
  end
  task complete_run();
    $display("Counts: %0d checked, %0d errors", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************
  // Bus and stimulus tasks
  // ****************************************
  // One APB transfer; the request holds until pready is sampled high.
  task apb(input logic w, input logic [6:0] idx, input logic [7:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {3'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [6:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task rdc(input string nm, input logic [6:0] idx, input logic [7:0] ex);
    apb(1'b0, idx, 8'h00);
    `CHK(nm, ex, r)
  endtask
  // Counter events held high for n cycles, then a settling gap for the interrupt path.
  task pulse(input logic [10:0] m, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      count_event <= m;
    end
    @(posedge ref_clk);
    count_event <= 11'h000;
    repeat (4) @(posedge ref_clk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_defaults();
    rdc("thr_hi", 7'h18, 8'hFF);
    rdc("cnt_mask", 7'h35, 8'h00);
    rdc("user_mask", 7'h39, 8'h00);
    rdc("top_mask", 7'h31, 8'h00);
    rdc("enable_a", 7'h2C, 8'h00);
    `CHK("reset_halt", 8'h00, reset_halt)
    apb(1'b0, 7'h17, 8'h00);
    `CHK("unmapped_err", 1'b1, e)
    $display("defaults done");
  endtask
  task t_overflow();
    wr(7'h2C, 8'hFF);
    wr(7'h2D, 8'h07);
    pulse(11'h7FF, 65536);
    rdc("pend_lo", 7'h32, 8'hFF);
    rdc("pend_mid", 7'h33, 8'h07);
    rdc("count0", 7'h01, 8'h00);
    wr(7'h32, 8'hFF);
    wr(7'h33, 8'hFF);
    rdc("pend_clr", 7'h32, 8'h00);
    $display("overflow done");
  endtask
  task t_irq();
    pulse(11'h100, 256);
    rdc("sum_masked", 7'h30, 8'h00);
    wr(7'h36, 8'h01);
    rdc("sum_cnt", 7'h30, 8'h01);
    `CHK("irq_masked", 1'b0, chiplet_irq_out)
    wr(7'h31, 8'h01);
    repeat (3) @(posedge ref_clk);
    `CHK("irq_on", 1'b1, chiplet_irq_out)
    `CHK("irq_edges", 8'h01, irq_edges)
    wr(7'h33, 8'h01);
    repeat (3) @(posedge ref_clk);
    `CHK("irq_off", 1'b0, chiplet_irq_out)
    @(posedge ref_clk) user_event <= 8'h08;
    @(posedge ref_clk) user_event <= 8'h00;
    rdc("user_pend", 7'h38, 8'h08);
    rdc("sum_umask", 7'h30, 8'h00);
    wr(7'h39, 8'h08);
    rdc("sum_user", 7'h30, 8'h02);
    @(posedge ref_clk) fatal_event <= 6'h01;
    @(posedge ref_clk) fatal_event <= 6'h00;
    rdc("sum_fatal", 7'h30, 8'h06);
    wr(7'h30, 8'h04);
    wr(7'h38, 8'h08);
    wr(7'h31, 8'h00);
    rdc("sum_clr", 7'h30, 8'h00);
    $display("interrupt tree done");
  endtask
  task t_thresh();
    wr(7'h1C, 8'h00);
    wr(7'h1D, 8'h02);
    wr(7'h1E, 8'h00);
    wr(7'h1F, 8'h03);
    pulse(11'h004, 3);
    rdc("degrade", 7'h33, 8'h20);
    pulse(11'h004, 1);
    rdc("fail", 7'h33, 8'h60);
    rdc("count2", 7'h05, 8'h04);
    $display("threshold done");
  endtask
  task t_counter();
    pulse(11'h001, 300);
    rdc("cnt0_lo", 7'h01, 8'h2C);
    rdc("snapshot", 7'h16, 8'h01);
    rdc("cnt0_keep", 7'h01, 8'h2C);
    rdc("cnt0_clr", 7'h00, 8'h2C);
    rdc("cnt0_zero", 7'h01, 8'h00);
    wr(7'h2C, 8'hFE);
    pulse(11'h001, 2);
    rdc("cnt0_off", 7'h01, 8'h00);
    wr(7'h2C, 8'hFF);
    wr(7'h2E, 8'h02);
    // The register takes the write at the edge that ends the task, so look one edge later.
    @(posedge ref_clk);
    `CHK("halt", 8'h02, reset_halt)
    pulse(11'h001, 3);
    rdc("cnt0_halt", 7'h01, 8'h00);
    @(posedge ref_clk) reset_req <= 1'b1;
    @(posedge ref_clk) reset_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK("preset", 8'h00, reset_halt)
    pulse(11'h001, 3);
    rdc("cnt0_run", 7'h01, 8'h03);
    // The clear-all bit empties every counter while it is held.
    wr(7'h2E, 8'h01);
    wr(7'h2E, 8'h00);
    rdc("cnt0_rhclr", 7'h01, 8'h00);
    $display("counter access done");
  endtask
  task t_mode();
    @(posedge ref_clk) mode_event <= 8'h20;
    @(posedge ref_clk) mode_event <= 8'h00;
    repeat (5) @(posedge ref_clk);
    rdc("mode_held", 7'h2F, 8'h20);
    wr(7'h2F, 8'h20);
    rdc("mode_clr", 7'h2F, 8'h00);
    $display("mode latch done");
  endtask
  initial begin
    {rstn, psel, penable, pwrite, reset_req} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    {count_event, mode_event, user_event, fatal_event} = 33'h0;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    t_defaults();
    t_overflow();
    t_irq();
    t_thresh();
    t_counter();
    t_mode();
    complete_run();
  end
endmodule // sdh_overhead_error_monitor_test
`default_nettype wire
